// file: rtl/ipmi_watchdog_command_unit.sv
// Purpose: Watchdog timer serviced by IPMI-style byte messages.
// Assumes: Bytes arrive already de-framed, on the system clock.
// Notes: Wishbone holds an action enable and a read-only status word.
`timescale 1ns/1ps
`include "watchdog_map.svh"

// How it works
// - Request 18h 25h returns current configuration
// - Replies open 1C, bus, command, completion
// - Query byte 1 bit 7 is no-log
// - Bit 6 shows running only if set with keep-running, clear once expired
// - Timer use codes live in bits 2:0
// - Pre-timeout interrupt select in bits 6:4
// - Expiry action code in bits 2:0
// - Pre-timeout interval byte in whole seconds
// - Expiration flags per use, 1 clears
// - Initial count 16 bits, LSB first, 100ms
// - Query ends with remaining count, LSB first
// - Reload 22 restarts count, acks 1C 00 22 00
// - Set 24 carries six configuration bytes
// - Expiry clears running, zero count, sets flag
// - All command traffic moves as serial byte messages; Wishbone carries only control and status
// - Countdown at zero fires selected action
// - Keep-running set reloads only running timer
module ipmi_watchdog_command_unit #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire watchdog_pkg::rx_byte_t rx_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output watchdog_pkg::expiry_act_t expiry_act_o,
  output watchdog_pkg::pre_irq_t pre_irq_o,
  output logic running_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0] req_reg [`REQ_MAX];
  logic [7:0] req_next [`REQ_MAX];
  logic [3:0] req_cnt_reg, req_cnt_next;
  watchdog_pkg::cmd_state_t state_reg, state_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [3:0] tx_len_reg, tx_len_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic [7:0] cc_reg, cc_next;
  logic [7:0] use_reg, use_next;
  logic [7:0] act_reg, act_next;
  logic [7:0] pre_reg, pre_next;
  logic [7:0] flags_reg, flags_next;
  logic [15:0] init_reg, init_next;
  logic [15:0] present_reg, present_next;
  logic running_reg, running_next;
  logic pre_done_reg, pre_done_next;
  logic [31:0] presc_reg, presc_next;
  watchdog_pkg::expiry_act_t exp_reg, exp_next;
  watchdog_pkg::pre_irq_t pirq_reg, pirq_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] wb_dat_reg, wb_dat_next;
  logic wb_ack_reg, wb_ack_next;
  logic tick;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [15:0] pre_ticks;

  ////////////////////////////////////////////////////////////////////////////
  // Response byte mux; configuration is read live when the byte before it is accepted, then held.
  function automatic logic [7:0] rsp_byte(input logic [3:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'h0: b = `NETFN_APP_RSP;
      4'h1: b = req_reg[1];
      4'h2: b = req_reg[2];
      4'h3: b = cc_reg;
      4'h4: begin
        b = use_reg & `USE_RSP_MASK;
        b[`USE_KEEP_BIT] = use_reg[`USE_KEEP_BIT] & running_reg;
      end
      4'h5: b = act_reg;
      4'h6: b = pre_reg;
      4'h7: b = flags_reg;
      4'h8: b = init_reg[7:0];
      4'h9: b = init_reg[15:8];
      4'ha: b = present_reg[7:0];
      4'hb: b = present_reg[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  assign rx_ready_o = (state_reg == watchdog_pkg::ST_RX);
  assign tx_valid_o = (state_reg == watchdog_pkg::ST_TX);
  assign tx_last_o = tx_valid_o && (tx_idx_reg == tx_len_reg - 4'h1);
  assign tx_data_o = tx_data_reg;
  assign expiry_act_o = exp_reg;
  assign pre_irq_o = pirq_reg;
  assign running_o = running_reg;
  assign wb_dat_o = wb_dat_reg;
  assign wb_ack_o = wb_ack_reg;
  assign pre_ticks = 16'(pre_reg * `TICKS_PER_SEC);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    req_next = req_reg;
    req_cnt_next = req_cnt_reg;
    state_next = state_reg;
    tx_idx_next = tx_idx_reg;
    tx_len_next = tx_len_reg;
    tx_data_next = tx_data_reg;
    cc_next = cc_reg;
    use_next = use_reg;
    act_next = act_reg;
    pre_next = pre_reg;
    init_next = init_reg;
    present_next = present_reg;
    running_next = running_reg;
    pre_done_next = pre_done_reg;
    exp_next = '0;
    pirq_next = '0;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    tick = 1'b0;
    ctrl_next = ctrl_reg;
    wb_dat_next = wb_dat_reg;
    wb_ack_next = 1'b0;

    // The prescaler runs free, so decrements are 100 ms apart but the first after a reload can come sooner.
    if (presc_reg == 32'(TICK_CYCLES - 1)) begin
      presc_next = 32'h0;
      tick = 1'b1;
    end else begin
      presc_next = presc_reg + 32'h1;
    end

    if (running_reg && tick) begin
      if (present_reg <= 16'h0001) begin
        present_next = 16'h0000;
        running_next = 1'b0;
        flag_set = (8'h01 << use_reg[2:0]) & `FLAGS_VALID_MASK;
        if (ctrl_reg[`CTRL_ACT_EN_BIT]) begin
          exp_next.hard_reset = (act_reg[2:0] == `ACT_EXP_HARD_RESET);
          exp_next.power_down = (act_reg[2:0] == `ACT_EXP_POWER_DOWN);
          exp_next.power_cycle = (act_reg[2:0] == `ACT_EXP_POWER_CYCLE);
        end
      end else begin
        present_next = present_reg - 16'h0001;
        if (!pre_done_reg && present_next == pre_ticks && pre_reg != 8'h00) begin
          pre_done_next = 1'b1;
          pirq_next.system_management_interrupt = (act_reg[6:4] == `ACT_PRE_SYS_MGMT);
          pirq_next.nmi = (act_reg[6:4] == `ACT_PRE_NMI);
          pirq_next.messaging = (act_reg[6:4] == `ACT_PRE_MSG);
        end
      end
    end

    case (state_reg)
      watchdog_pkg::ST_RX: begin
        if (rx_valid_i) begin
          if (req_cnt_reg < 4'(`REQ_MAX)) begin
            req_next[req_cnt_reg] = rx_i.data;
            req_cnt_next = req_cnt_reg + 4'h1;
          end
          if (rx_i.last) begin
            state_next = watchdog_pkg::ST_EXEC;
          end
        end
      end
      watchdog_pkg::ST_EXEC: begin
        cc_next = `CC_OK;
        tx_len_next = `RSP_LEN_SHORT;
        if (req_reg[0] != `NETFN_APP_REQ || req_cnt_reg < 4'h3) begin
          cc_next = `CC_BAD_CMD;
        end else if (req_reg[2] == `CMD_RELOAD) begin
          present_next = init_reg;
          running_next = 1'b1;
          pre_done_next = 1'b0;
        end else if (req_reg[2] == `CMD_SET) begin
          if (req_cnt_reg < `SET_REQ_LEN) begin
            cc_next = `CC_BAD_LEN;
          end else begin
            use_next = req_reg[3] & `USE_KEEP_MASK;
            act_next = req_reg[4] & `ACT_KEEP_MASK;
            pre_next = req_reg[5];
            flag_clr = req_reg[6] & `FLAGS_VALID_MASK;
            init_next = {req_reg[8], req_reg[7]};
            pre_done_next = 1'b0;
            if (req_reg[3][`USE_KEEP_BIT]) begin
              if (running_reg) begin
                present_next = {req_reg[8], req_reg[7]};
              end
            end else begin
              running_next = 1'b0;
            end
          end
        end else if (req_reg[2] == `CMD_GET) begin
          tx_len_next = `RSP_LEN_GET;
        end else begin
          cc_next = `CC_BAD_CMD;
        end
        tx_idx_next = 4'h0;
        tx_data_next = `NETFN_APP_RSP;
        req_cnt_next = 4'h0;
        state_next = watchdog_pkg::ST_TX;
      end
      watchdog_pkg::ST_TX: begin
        if (tx_ready_i) begin
          if (tx_idx_reg == tx_len_reg - 4'h1) begin
            state_next = watchdog_pkg::ST_RX;
          end else begin
            tx_idx_next = tx_idx_reg + 4'h1;
            tx_data_next = rsp_byte(tx_idx_reg + 4'h1);
          end
        end
      end
      default: state_next = watchdog_pkg::ST_RX;
    endcase

    // An expiry in the same cycle as a clear mask leaves its flag set.
    flags_next = (flags_reg & ~flag_clr) | flag_set;

    // Wishbone slave, one wait state; unmapped reads return zero.
    if (wb_cyc_i && wb_stb_i && !wb_ack_reg) begin
      wb_ack_next = 1'b1;
      wb_dat_next = 32'h0;
      if (wb_adr_i == `OFS_CTRL) begin
        if (wb_we_i && wb_sel_i[0]) begin
          ctrl_next[0] = wb_dat_i[0];
        end
        wb_dat_next = ctrl_reg;
      end else if (wb_adr_i == `OFS_STATUS) begin
        wb_dat_next = {7'h0, running_reg, flags_reg, present_reg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `REQ_MAX; i++) begin
        req_reg[i] <= 8'h00;
      end
      req_cnt_reg <= 4'h0;
      state_reg <= watchdog_pkg::ST_RX;
      tx_idx_reg <= 4'h0;
      tx_len_reg <= `RSP_LEN_SHORT;
      tx_data_reg <= 8'h00;
      cc_reg <= `CC_OK;
      use_reg <= 8'h00;
      act_reg <= 8'h00;
      pre_reg <= 8'h00;
      flags_reg <= 8'h00;
      init_reg <= 16'h0000;
      present_reg <= 16'h0000;
      running_reg <= 1'b0;
      pre_done_reg <= 1'b0;
      presc_reg <= 32'h0;
      exp_reg <= '0;
      pirq_reg <= '0;
      ctrl_reg <= `CTRL_RESET;
      wb_dat_reg <= 32'h0;
      wb_ack_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      req_cnt_reg <= req_cnt_next;
      state_reg <= state_next;
      tx_idx_reg <= tx_idx_next;
      tx_len_reg <= tx_len_next;
      tx_data_reg <= tx_data_next;
      cc_reg <= cc_next;
      use_reg <= use_next;
      act_reg <= act_next;
      pre_reg <= pre_next;
      flags_reg <= flags_next;
      init_reg <= init_next;
      present_reg <= present_next;
      running_reg <= running_next;
      pre_done_reg <= pre_done_next;
      presc_reg <= presc_next;
      exp_reg <= exp_next;
      pirq_reg <= pirq_next;
      ctrl_reg <= ctrl_next;
      wb_dat_reg <= wb_dat_next;
      wb_ack_reg <= wb_ack_next;
    end
  end

endmodule

// file: rtl/watchdog_map.svh
// Purpose: Constants of the watchdog command unit.
// Assumes: 20 MHz system clock.
// Notes: Offsets are byte addresses on the register bus.
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH
`define NETFN_APP_REQ 8'h18
`define NETFN_APP_RSP 8'h1c
`define CMD_RELOAD 8'h22
`define CMD_SET 8'h24
`define CMD_GET 8'h25
`define CC_OK 8'h00
`define CC_BAD_CMD 8'hc1
`define CC_BAD_LEN 8'hc7
`define SET_REQ_LEN 4'h9
`define RSP_LEN_SHORT 4'h4
`define RSP_LEN_GET 4'hc
`define REQ_MAX 9
`define USE_KEEP_MASK 8'hc7
`define ACT_KEEP_MASK 8'h77
`define FLAGS_VALID_MASK 8'h3e
`define USE_LOG_BIT 7
`define USE_KEEP_BIT 6
`define USE_RSP_MASK 8'h87
`define ACT_EXP_HARD_RESET 3'h1
`define ACT_EXP_POWER_DOWN 3'h2
`define ACT_EXP_POWER_CYCLE 3'h3
`define ACT_PRE_SYS_MGMT 3'h1
`define ACT_PRE_NMI 3'h2
`define ACT_PRE_MSG 3'h3
`define TICK_MS 100
`define CLK_HZ 20000000
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_SEC 16'h000a
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define CTRL_RESET 32'h0000_0001
`define CTRL_ACT_EN_BIT 0
`endif

// file: rtl/watchdog_pkg.sv
// Purpose: Types of the watchdog command unit.
// Assumes: Nothing beyond the constants header.
// Notes: Structs carry grouped pins.
package watchdog_pkg;
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_TX} cmd_state_t;
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rx_byte_t;
  typedef struct packed {
    logic power_cycle;
    logic power_down;
    logic hard_reset;
  } expiry_act_t;
  typedef struct packed {
    logic messaging;
    logic nmi;
    logic system_management_interrupt;
  } pre_irq_t;
endpackage

// file: sim/ipmi_watchdog_command_unit_test.sv
// Purpose: Self-checking bench of the watchdog command unit.
// Assumes: Tick shortened to 4 cycles.
// Notes: Ends through results.
`timescale 1ns/1ps
module ipmi_watchdog_command_unit_test;
  localparam int TK = 4;
  logic clk_i, rst_i = 1'b1, rxv, rxr, txv, txl, txr, run, cyc, stb, we, ack;
  watchdog_pkg::rx_byte_t rx;
  watchdog_pkg::expiry_act_t act;
  watchdog_pkg::pre_irq_t pre;
  logic [7:0] txd;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic [3:0] sel = 4'h0;
  logic [2:0] pre_seen = 3'h0, act_seen = 3'h0;
  logic [7:0] r[$];
  int n_errors = 0, checks_done = 0, cn = 0, n_pre = 0, n_act = 0, t_pre = 0, t_act = 0;
  ipmi_watchdog_command_unit #(.TICK_CYCLES(TK)) u_ipmi_watchdog_command_unit (
    .clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rxv), .rx_i(rx), .rx_ready_o(rxr),
    .tx_valid_o(txv), .tx_data_o(txd), .tx_last_o(txl), .tx_ready_i(txr),
    .expiry_act_o(act), .pre_irq_o(pre), .running_o(run), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack));
  watchdog_host_model u_watchdog_host_model (.clk_i(clk_i), .rx_valid_o(rxv), .rx_o(rx),
    .rx_ready_i(rxr), .tx_valid_i(txv), .tx_data_i(txd), .tx_last_i(txl), .tx_ready_o(txr));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Only the first n bytes are compared; live countdown bytes move.
  task automatic chkr(input logic [7:0] e[$], input int n);
    chkw(r.size(), e.size());
    for (int i = 0; i < n && i < r.size(); i++) chkw(r[i], e[i]);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Any pulse is counted and remembered, so a wrong line shows up too.
  always @(posedge clk_i) begin
    cn <= cn + 1;
    if (|pre === 1'b1) begin
      n_pre++;
      t_pre = cn;
      pre_seen = pre;
    end
    if (|act === 1'b1) begin
      n_act++;
      t_act = cn;
      act_seen = act;
    end
    if (cn == 5000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    chkw(q, 32'h1);
    wb(1'b1, 4'h0, 32'h0, 4'he);
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    chkw(q, 32'h1);
    wb(1'b1, 4'h0, 32'h0, 4'hf);
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    chkw(q, 32'h0);
    wb(1'b1, 4'h0, 32'h1, 4'hf);
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    chkw(q, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_set_get();
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h43, 8'h01, 8'h01, 8'h08,
      8'h50, 8'h00}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'h00}, 4);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h22}, r);
    chkr('{8'h1c, 8'h00, 8'h22, 8'h00}, 4);
    chkw(run, 1'b1);
    u_watchdog_host_model.slow = 1'b1;
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    u_watchdog_host_model.slow = 1'b0;
    chkr('{8'h1c, 8'h00, 8'h25, 8'h00, 8'h43, 8'h01, 8'h01, 8'h00, 8'h50, 8'h00,
      8'h0, 8'h0}, 10);
    chkw(r[11], 8'h00);
    chkw(r[10] > 8'h30 && r[10] < 8'h50, 1'b1);
    $display("test set_get done");
  endtask
  task automatic t_expire();
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h43, 8'h21, 8'h01, 8'h00,
      8'h50, 8'h00}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'h00}, 4);
    chkw(run, 1'b1);
    n_pre = 0;
    n_act = 0;
    while (run === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chkw(n_pre, 1);
    chkw(pre_seen, 3'h2);
    chkw(n_act, 1);
    chkw(act_seen, 3'h1);
    chkw(t_act - t_pre, 10 * TK);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    chkr('{8'h1c, 8'h00, 8'h25, 8'h00, 8'h03, 8'h21, 8'h01, 8'h08, 8'h50, 8'h00,
      8'h00, 8'h00}, 12);
    wb(1'b0, 4'h4, 32'h0, 4'hf);
    chkw(q, 32'h0008_0000);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h43, 8'h21, 8'h01, 8'h08,
      8'h50, 8'h00}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'h00}, 4);
    chkw(run, 1'b0);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    chkw(r[7], 8'h00);
    $display("test expire done");
  endtask
  task automatic t_actions();
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h26}, r);
    chkr('{8'h1c, 8'h00, 8'h26, 8'hc1}, 4);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h04}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'hc7}, 4);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h04, 8'h33, 8'h01, 8'h00,
      8'h0c, 8'h00}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'h00}, 4);
    chkw(run, 1'b0);
    n_pre = 0;
    n_act = 0;
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h22}, r);
    chkr('{8'h1c, 8'h00, 8'h22, 8'h00}, 4);
    while (run === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chkw(n_pre, 1);
    chkw(pre_seen, 3'h4);
    chkw(n_act, 1);
    chkw(act_seen, 3'h4);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    chkr('{8'h1c, 8'h00, 8'h25, 8'h00, 8'h04, 8'h33, 8'h01, 8'h10, 8'h0c, 8'h00,
      8'h00, 8'h00}, 12);
    wb(1'b1, 4'h0, 32'h0, 4'hf);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h24, 8'h01, 8'h12, 8'h01, 8'h3e,
      8'h0c, 8'h00}, r);
    chkr('{8'h1c, 8'h00, 8'h24, 8'h00}, 4);
    n_pre = 0;
    n_act = 0;
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h22}, r);
    while (run === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chkw(n_pre, 1);
    chkw(pre_seen, 3'h1);
    chkw(n_act, 0);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    chkr('{8'h1c, 8'h00, 8'h25, 8'h00, 8'h01, 8'h12, 8'h01, 8'h02, 8'h0c, 8'h00,
      8'h00, 8'h00}, 12);
    wb(1'b1, 4'h0, 32'h1, 4'hf);
    $display("test actions done");
  endtask
  task automatic t_reset();
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h22}, r);
    chkw(run, 1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chkw(run, 1'b0);
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    chkw(q, 32'h1);
    u_watchdog_host_model.xfer('{8'h18, 8'h00, 8'h25}, r);
    chkr('{8'h1c, 8'h00, 8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00}, 12);
    $display("test reset done");
  endtask
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_set_get();
    t_expire();
    t_actions();
    t_reset();
    results();
  end
endmodule

// file: sim/watchdog_assertions.sv
// Purpose: Port assertions of the watchdog command unit.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the unit.
`timescale 1ns/1ps
module watchdog_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire watchdog_pkg::rx_byte_t rx_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire watchdog_pkg::expiry_act_t expiry_act_o,
  input wire watchdog_pkg::pre_irq_t pre_irq_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rsp_start: assert property (
    rx_valid_i && rx_ready_o && rx_i.last |-> ##2 tx_valid_o && tx_data_o == 8'h1c)
    else $error("reply did not start with 1c");
  a_rx_closed: assert property (
    rx_valid_i && rx_ready_o && rx_i.last |=> !rx_ready_o [*2])
    else $error("request bytes taken during execution");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("stalled reply byte changed");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o && !rx_ready_o)
    else $error("last flag without reply byte");
  a_act_pulse: assert property (
    |expiry_act_o |-> $onehot(expiry_act_o) ##1 expiry_act_o == 3'h0)
    else $error("expiry action not a single pulse");
  a_pre_pulse: assert property (
    |pre_irq_o |-> $onehot(pre_irq_o) ##1 pre_irq_o == 3'h0)
    else $error("pre-timeout not a single pulse");
  a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind ipmi_watchdog_command_unit watchdog_assertions u_watchdog_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_i(rx_i),
  .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .expiry_act_o(expiry_act_o),
  .pre_irq_o(pre_irq_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// file: sim/watchdog_host_model.sv
// Purpose: Host that sends request bytes and takes response bytes.
// Assumes: Called right after a rising clock edge.
// Notes: slow=1 drops ready every other cycle, so each response byte, the first included, is stalled one cycle.
`timescale 1ns/1ps
module watchdog_host_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output watchdog_pkg::rx_byte_t rx_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic slow = 1'b0;
  initial begin
    rx_valid_o = 1'b0;
    rx_o = '0;
    tx_ready_o = 1'b0;
  end
  // Netfn, bus and command lead every request.
  task automatic xfer(input logic [7:0] q[$], output logic [7:0] r[$]);
    logic done;
    r = {};
    for (int i = 0; i < q.size(); i++) begin
      rx_valid_o <= 1'b1;
      rx_o <= '{last: (i == q.size() - 1), data: q[i]};
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    // A released line shows the inverse so a stale byte cannot pass.
    rx_valid_o <= 1'b0;
    rx_o.data <= ~q[q.size() - 1];
    done = 1'b0;
    while (!done) begin
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
      @(posedge clk_i);
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
        r.push_back(tx_data_i);
        done = tx_last_i;
      end
    end
    tx_ready_o <= 1'b0;
  endtask
endmodule
